// ---- logic/focpsr_params.svh ----
// register offsets, field widths and reset values of the position and speed register group
`ifndef FOCPSR_PARAMS_SVH
`define FOCPSR_PARAMS_SVH
`define FOCPSR_OFS_VOLT_ANGLE    8'h00
`define FOCPSR_OFS_ROT_INIT      8'h04
`define FOCPSR_OFS_ROT_ANGLE     8'h08
`define FOCPSR_OFS_SPD_COEF_A    8'h0C
`define FOCPSR_OFS_SPD_COEF_B    8'h10
`define FOCPSR_OFS_SPD_VALUE     8'h14
`define FOCPSR_OFS_OBS_VGAIN     8'h18
`define FOCPSR_OFS_OBS_IGAIN     8'h1C
`define FOCPSR_OFS_OBS_ERRLIM    8'h20
`define FOCPSR_OFS_BEMF_F1       8'h24
`define FOCPSR_OFS_BEMF_F2LO     8'h28
`define FOCPSR_OFS_BEMF_F2SPAN   8'h2C
`define FOCPSR_OFS_BEMF_F2LIVE   8'h30
`define FOCPSR_OFS_OBS_ANGOFS    8'h34
`define FOCPSR_OFS_BEMF_ANGLE    8'h38
`define FOCPSR_OFS_BEMF_MAG      8'h3C
`define FOCPSR_OFS_OBS_ANGLE     8'h40
`define FOCPSR_OFS_TURNS_POS     8'h44
`define FOCPSR_OFS_SPD_SETPOINT  8'h48
`define FOCPSR_OFS_SPD_PGAIN     8'h4C
`define FOCPSR_OFS_LOOP_CTRL     8'h50
`define FOCPSR_ADDR_BITS         8
`define FOCPSR_COEF_BITS         17
`define FOCPSR_OFS16_BITS        16
`define FOCPSR_POS_SHIFT         16
`define FOCPSR_CTRL_SPD2CUR_BIT  0
`define FOCPSR_CTRL_SPD2POS_BIT  1
`define FOCPSR_CTRL_SEL_LSB      2
`define FOCPSR_RESET_WORD        32'h00000000
`endif

// ---- logic/focpsr_pkg.sv ----
// types shared by the position and speed register group
package focpsr_pkg;
    // rotor angle sources selectable by the rotor source select field
    typedef enum logic [1:0] {
        focpsr_src_observer,
        focpsr_src_external,
        focpsr_src_speed_int,
        focpsr_src_default
    } focpsr_src_t;
endpackage

// ---- logic/focpsr_lpf_if.sv ----
// carrier between register bank and speed filter
`timescale 1ns/10ps
interface focpsr_lpf_if;
    logic        [16:0] coef_a;   // stage one weight
    logic        [16:0] coef_b;   // stage two weight
    logic               sample_en; // core activation strobe
    logic signed [31:0] sample;   // raw speed sample
    logic               clear;    // core reset
    logic signed [31:0] result;   // filtered speed
    modport bank (output coef_a, output coef_b, output sample_en, output sample, output clear, input result);
    modport filt (input coef_a, input coef_b, input sample_en, input sample, input clear, output result);
endinterface

// ---- logic/focpsr_speed_filter.sv ----
// two cascaded first order low-pass stages for speed evaluation
`timescale 1ns/10ps
`include "focpsr_params.svh"
module focpsr_speed_filter
(
    input  wire logic   hclk,
    input  wire logic   hresetn,
    focpsr_lpf_if.filt  lpf
);
    // accumulators of both stages
    typedef struct packed {
        logic signed [31:0] acc1;
        logic signed [31:0] acc2;
    } focpsr_filt_state_t;

    focpsr_filt_state_t st;      // registered state
    focpsr_filt_state_t next_st; // next state

    // y = y + (x - y) * k, k = coef / 2^17; wide math avoids overflow of the difference
    function automatic logic signed [31:0] lpf_step(input logic signed [31:0] y, input logic signed [31:0] x,
                                                    input logic [16:0] k);
        logic signed [33:0] diff;
        logic signed [51:0] prod;
        diff = 34'(x) - 34'(y);
        prod = 52'(diff) * $signed({35'h0, k});
        return 32'(34'(y) + 34'(prod >>> `FOCPSR_COEF_BITS));
    endfunction

    // one update per activation; stage two eats stage one's new output
    always_comb
    begin
        next_st = st;
        if (lpf.clear)
        begin
            next_st = '0;
        end
        else if (lpf.sample_en)
        begin
            next_st.acc1 = lpf_step(st.acc1, lpf.sample, lpf.coef_a);
            next_st.acc2 = lpf_step(st.acc2, next_st.acc1, lpf.coef_b);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign lpf.result = st.acc2; // accumulator is also the output
endmodule

// ---- logic/focpsr_regs.sv ----
// AHB-Lite register bank for rotor position, speed filter, observer and speed loop settings
// What this block does
// - voltage vector angle: read-only live 32-bit angle
// - initial angle RW, loaded on core resets
// - rotor angle read-only, from selected source
// - core reset: rotor angle default for external/default source, else initial
// - speed filter: two cascaded stages, A, B
// - stage: acc += (sample - acc) * K
// - coefficient 17-bit unsigned, K = value/2^17
// - filter updates once per core activation
// - electric speed read-only signed 32-bit
// - observer voltage/current gains RW, feed observer
// - error limit 17 bits, upper zero
// - back-EMF filter one coefficient 17-bit writable
// - filter two low coefficient: zero-speed cutoff
// - filter two span widens cutoff with speed
// - angle offset signed 16, added to angle
// - back-EMF angle read-only unsigned 32-bit
// - back-EMF magnitude read-only 17 bits
// - observer rotor angle read-only 32-bit
// - turns position unsigned, 2^16 per turn
// - speed setpoint RW, drives current loop
// - speed-feeds-position flag feeds position loop
// - proportional gain RW float, shifted by parameter
//
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "focpsr_params.svh"
module focpsr_regs
    import focpsr_pkg::*;
#(
    parameter int PROP_GAIN_SHIFT = 8 // proportional gain shift parameter
)
(
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire logic                core_reset,
    input  wire logic                core_activate,
    input  wire logic [31:0]         volt_vector_angle_in,
    input  wire logic [31:0]         external_angle_in,
    input  wire logic [31:0]         feedback_default_angle,
    input  wire logic signed [31:0]  speed_sample_in,
    input  wire logic [31:0]         bemf_angle_in,
    input  wire logic [16:0]         bemf_magnitude_in,
    input  wire logic [31:0]         observer_angle_in,
    output logic [31:0]              initial_angle_out,
    output logic                     initial_angle_load,
    output logic [31:0]              rotor_angle,
    output logic signed [31:0]       electric_speed,
    output logic [31:0]              observer_voltage_gain,
    output logic [31:0]              observer_current_gain,
    output logic [16:0]              observer_error_limit,
    output logic [16:0]              bemf_filter_one_coef,
    output logic [16:0]              bemf_filter_two_coef_live,
    output logic [31:0]              observer_angle_corrected,
    output logic signed [31:0]       speed_loop_setpoint,
    output logic [31:0]              speed_loop_prop_gain,
    output logic [7:0]               prop_gain_shift,
    output logic                     speed_feeds_current_loop,
    output logic                     speed_feeds_position_loop,
    output logic signed [31:0]       speed_to_current_cmd,
    output logic signed [31:0]       speed_to_position_cmd
);
    import focpsr_pkg::*;

    // whole state of the bank
    typedef struct packed {
        logic                      wr_pend;   // data phase of a write pending
        logic [`FOCPSR_ADDR_BITS-1:0] wr_addr; // latched write offset
        logic [31:0]               rdata;     // registered read data
        logic [31:0]               rot_init;
        logic [16:0]               coef_a;
        logic [16:0]               coef_b;
        logic [31:0]               vgain;
        logic [31:0]               igain;
        logic [16:0]               errlim;
        logic [16:0]               f1;
        logic [16:0]               f2lo;
        logic [16:0]               f2span;
        logic [16:0]               f2live;    // speed-dependent cutoff
        logic [15:0]               angofs;
        logic signed [31:0]        setpoint;
        logic [31:0]               pgain;
        logic                      spd2cur;
        logic                      spd2pos;
        focpsr_src_t               src_sel;
        logic [31:0]               rot_angle; // selected live angle
        logic [31:0]               speed_int; // angle integrated from filtered speed
        logic                      load;      // initial angle load strobe
    } focpsr_state_t;

    focpsr_state_t st;      // registered state
    focpsr_state_t next_st; // next state

    focpsr_lpf_if lpf (); // link to the speed filter

    focpsr_speed_filter u_filter
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .lpf     (lpf)
    );

    logic        addr_ok;   // valid NONSEQ/SEQ selected transfer
    logic [31:0] rd_mux;    // combinational read mux
    logic [31:0] sel_angle; // angle picked by the source select
    logic [33:0] span_prod; // span scaled by speed magnitude
    logic [31:0] spd_abs;   // magnitude of filtered speed

    assign addr_ok = hsel && hready && htrans[1];

    // feed the filter
    assign lpf.coef_a    = st.coef_a;
    assign lpf.coef_b    = st.coef_b;
    assign lpf.sample_en = core_activate;
    assign lpf.sample    = speed_sample_in;
    assign lpf.clear     = core_reset;

    // pick the live rotor angle
    always_comb
    begin
        case (st.src_sel)
            focpsr_src_observer:  sel_angle = observer_angle_in + {{16{st.angofs[15]}}, st.angofs};
            focpsr_src_external:  sel_angle = external_angle_in;
            focpsr_src_speed_int: sel_angle = st.speed_int;
            focpsr_src_default:   sel_angle = feedback_default_angle;
            default:              sel_angle = feedback_default_angle;
        endcase
    end

    // cutoff of back-EMF stage two rises with the speed magnitude, clamped to 17 bits
    always_comb
    begin
        spd_abs   = lpf.result[31] ? 32'(-lpf.result) : 32'(lpf.result);
        span_prod = 34'(st.f2span) * 34'(spd_abs[31:16]);
    end

    // register read mux; reserved upper bits are zero
    always_comb
    begin
        case (haddr[`FOCPSR_ADDR_BITS-1:0])
            `FOCPSR_OFS_VOLT_ANGLE:   rd_mux = volt_vector_angle_in;
            `FOCPSR_OFS_ROT_INIT:     rd_mux = st.rot_init;
            `FOCPSR_OFS_ROT_ANGLE:    rd_mux = st.rot_angle;
            `FOCPSR_OFS_SPD_COEF_A:   rd_mux = {15'h0000, st.coef_a};
            `FOCPSR_OFS_SPD_COEF_B:   rd_mux = {15'h0000, st.coef_b};
            `FOCPSR_OFS_SPD_VALUE:    rd_mux = lpf.result;
            `FOCPSR_OFS_OBS_VGAIN:    rd_mux = st.vgain;
            `FOCPSR_OFS_OBS_IGAIN:    rd_mux = st.igain;
            `FOCPSR_OFS_OBS_ERRLIM:   rd_mux = {15'h0000, st.errlim};
            `FOCPSR_OFS_BEMF_F1:      rd_mux = {15'h0000, st.f1};
            `FOCPSR_OFS_BEMF_F2LO:    rd_mux = {15'h0000, st.f2lo};
            `FOCPSR_OFS_BEMF_F2SPAN:  rd_mux = {15'h0000, st.f2span};
            `FOCPSR_OFS_BEMF_F2LIVE:  rd_mux = {15'h0000, st.f2live};
            `FOCPSR_OFS_OBS_ANGOFS:   rd_mux = {16'h0000, st.angofs};
            `FOCPSR_OFS_BEMF_ANGLE:   rd_mux = bemf_angle_in;
            `FOCPSR_OFS_BEMF_MAG:     rd_mux = {15'h0000, bemf_magnitude_in};
            `FOCPSR_OFS_OBS_ANGLE:    rd_mux = observer_angle_in;
            `FOCPSR_OFS_TURNS_POS:    rd_mux = 32'(st.rot_angle >> `FOCPSR_POS_SHIFT);
            `FOCPSR_OFS_SPD_SETPOINT: rd_mux = st.setpoint;
            `FOCPSR_OFS_SPD_PGAIN:    rd_mux = st.pgain;
            `FOCPSR_OFS_LOOP_CTRL:    rd_mux = {28'h0000000, st.src_sel, st.spd2pos, st.spd2cur};
            default:                  rd_mux = 32'h00000000;
        endcase
    end

    // bus phases, register writes, rotor angle tracking
    always_comb
    begin
        next_st      = st;
        next_st.load = 1'b0;
        // address phase: latch write target, capture read data for the data phase
        next_st.wr_pend = addr_ok && hwrite;
        if (addr_ok)
        begin
            next_st.wr_addr = haddr[`FOCPSR_ADDR_BITS-1:0];
        end
        if (addr_ok && !hwrite)
        begin
            next_st.rdata = rd_mux;
        end
        // data phase: store writable fields only, others ignored
        if (st.wr_pend)
        begin
            case (st.wr_addr)
                `FOCPSR_OFS_ROT_INIT:     next_st.rot_init = hwdata;
                `FOCPSR_OFS_SPD_COEF_A:   next_st.coef_a   = hwdata[16:0];
                `FOCPSR_OFS_SPD_COEF_B:   next_st.coef_b   = hwdata[16:0];
                `FOCPSR_OFS_OBS_VGAIN:    next_st.vgain    = hwdata;
                `FOCPSR_OFS_OBS_IGAIN:    next_st.igain    = hwdata;
                `FOCPSR_OFS_OBS_ERRLIM:   next_st.errlim   = hwdata[16:0];
                `FOCPSR_OFS_BEMF_F1:      next_st.f1       = hwdata[16:0];
                `FOCPSR_OFS_BEMF_F2LO:    next_st.f2lo     = hwdata[16:0];
                `FOCPSR_OFS_BEMF_F2SPAN:  next_st.f2span   = hwdata[16:0];
                `FOCPSR_OFS_OBS_ANGOFS:   next_st.angofs   = hwdata[15:0];
                `FOCPSR_OFS_SPD_SETPOINT: next_st.setpoint = hwdata;
                `FOCPSR_OFS_SPD_PGAIN:    next_st.pgain    = hwdata;
                `FOCPSR_OFS_LOOP_CTRL:
                begin
                    next_st.spd2cur = hwdata[`FOCPSR_CTRL_SPD2CUR_BIT];
                    next_st.spd2pos = hwdata[`FOCPSR_CTRL_SPD2POS_BIT];
                    next_st.src_sel = focpsr_src_t'(hwdata[`FOCPSR_CTRL_SEL_LSB +: 2]);
                end
                default:
                begin
                    next_st.load = 1'b0; // read-only or unmapped offset: write dropped
                end
            endcase
        end
        // live cutoff: low coefficient plus span term, saturated at the 17-bit ceiling
        if (34'(st.f2lo) + (span_prod >> 16) > 34'h1FFFF)
            next_st.f2live = 17'h1FFFF;
        else
            next_st.f2live = 17'(34'(st.f2lo) + (span_prod >> 16));
        // core reset reloads the integrator and picks the default angle for default and external sources, else the initial angle
        if (core_reset)
        begin
            next_st.load      = 1'b1;
            next_st.speed_int = st.rot_init;
            next_st.rot_angle = (st.src_sel == focpsr_src_default || st.src_sel == focpsr_src_external)
                                ? feedback_default_angle : st.rot_init;
        end
        else
        begin
            if (core_activate)
            begin
                next_st.speed_int = st.speed_int + 32'(lpf.result);
            end
            next_st.rot_angle = sel_angle;
        end
    end

    // register the state; everything but the load strobe clears to zero; first cycle after reset loads the initial angle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st      <= '0;
            st.load <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // outputs
    assign hrdata                    = st.rdata;
    assign hreadyout                 = 1'b1;
    assign hresp                     = 1'b0;
    assign initial_angle_out         = st.rot_init;
    assign initial_angle_load        = st.load;
    assign rotor_angle               = st.rot_angle;
    assign electric_speed            = lpf.result;
    assign observer_voltage_gain     = st.vgain;
    assign observer_current_gain     = st.igain;
    assign observer_error_limit      = st.errlim;
    assign bemf_filter_one_coef      = st.f1;
    assign bemf_filter_two_coef_live = st.f2live;
    assign observer_angle_corrected  = observer_angle_in + {{16{st.angofs[15]}}, st.angofs};
    assign speed_loop_setpoint       = st.setpoint;
    assign speed_loop_prop_gain      = st.pgain;
    assign prop_gain_shift           = 8'(PROP_GAIN_SHIFT);
    assign speed_feeds_current_loop  = st.spd2cur;
    assign speed_feeds_position_loop = st.spd2pos;
    assign speed_to_current_cmd      = st.spd2cur ? st.setpoint : 32'sh00000000;
    assign speed_to_position_cmd     = st.spd2pos ? lpf.result : 32'sh00000000;
endmodule

// ---- verif/focpsr_regs_asserts.sv ----
// concurrent checks on the ports of the position and speed register bank
`timescale 1ns/10ps
module focpsr_regs_asserts
#(
    parameter int PROP_GAIN_SHIFT = 8 // handed down from the bank
)
(
    input wire logic               hclk,
    input wire logic               hresetn,
    input wire logic               hsel,
    input wire logic [31:0]        haddr,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic               hready,
    input wire logic [31:0]        hrdata,
    input wire logic               hreadyout,
    input wire logic               hresp,
    input wire logic               core_reset,
    input wire logic               core_activate,
    input wire logic [31:0]        volt_vector_angle_in,
    input wire logic [31:0]        feedback_default_angle,
    input wire logic [31:0]        observer_angle_in,
    input wire logic [31:0]        initial_angle_out,
    input wire logic               initial_angle_load,
    input wire logic [31:0]        rotor_angle,
    input wire logic signed [31:0] electric_speed,
    input wire logic [31:0]        observer_angle_corrected,
    input wire logic signed [31:0] speed_loop_setpoint,
    input wire logic [7:0]         prop_gain_shift,
    input wire logic               speed_feeds_current_loop,
    input wire logic               speed_feeds_position_loop,
    input wire logic signed [31:0] speed_to_current_cmd,
    input wire logic signed [31:0] speed_to_position_cmd
);
    logic [31:0] ofs_diff; // offset the bank added to the observer angle
    assign ofs_diff = observer_angle_corrected - observer_angle_in;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // read of the voltage angle taken at an address edge
    sequence s_volt_rd;
        hsel && hready && htrans[1] && !hwrite && haddr[7:0] == 8'h00;
    endsequence
    // two cycles with neither a filter step nor a core reset
    sequence s_idle2;
        (!core_activate && !core_reset) [*2];
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready and okay");
    a_volt_read: assert property (s_volt_rd |=> hrdata == $past(volt_vector_angle_in))
        else $error("voltage angle read mismatch");
    a_init_load: assert property ($rose(core_reset) |=> initial_angle_load)
        else $error("initial angle not loaded after core reset");
    // the held angle is either the default or the initial one, per source
    a_core_angle: assert property (core_reset |=> rotor_angle == $past(feedback_default_angle) ||
        rotor_angle == $past(initial_angle_out)) else $error("rotor angle wrong during core reset");
    a_speed_hold: assert property (s_idle2 |=> $stable(electric_speed))
        else $error("speed moved without a filter step");
    a_cur_cmd: assert property (speed_feeds_current_loop ? speed_to_current_cmd == speed_loop_setpoint :
        speed_to_current_cmd == 32'sh0) else $error("current command does not follow flag");
    a_pos_cmd_off: assert property (!speed_feeds_position_loop |-> speed_to_position_cmd == 32'sh0)
        else $error("position command active with flag clear");
    a_ofs_sext: assert property (ofs_diff[31:16] == {16{ofs_diff[15]}})
        else $error("angle offset not a sign extended 16 bit value");
    a_gain_shift: assert property (prop_gain_shift == 8'(PROP_GAIN_SHIFT))
        else $error("gain shift port differs from parameter");
endmodule
bind focpsr_regs focpsr_regs_asserts #(.PROP_GAIN_SHIFT(PROP_GAIN_SHIFT)) u_focpsr_regs_asserts (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .core_reset(core_reset),
    .core_activate(core_activate), .volt_vector_angle_in(volt_vector_angle_in),
    .feedback_default_angle(feedback_default_angle), .observer_angle_in(observer_angle_in),
    .initial_angle_out(initial_angle_out), .initial_angle_load(initial_angle_load),
    .rotor_angle(rotor_angle), .electric_speed(electric_speed),
    .observer_angle_corrected(observer_angle_corrected), .speed_loop_setpoint(speed_loop_setpoint),
    .prop_gain_shift(prop_gain_shift), .speed_feeds_current_loop(speed_feeds_current_loop),
    .speed_feeds_position_loop(speed_feeds_position_loop),
    .speed_to_current_cmd(speed_to_current_cmd), .speed_to_position_cmd(speed_to_position_cmd));

// ---- verif/tb_top.sv ----
// self-checking bench for the position and speed register bank
`timescale 1ns/10ps
`define CHK(a, x) begin tests_run++; if ((a) !== (x)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (x)); end end
module tb_top;
    localparam int SH = 5; // non-default shift, proves it reaches the port
    localparam logic [7:0] OFS [12] = '{8'h04, 8'h0C, 8'h10, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C,
        8'h34, 8'h48, 8'h4C};
    localparam logic [31:0] MSK [12] = '{32'hFFFFFFFF, 32'h1FFFF, 32'h1FFFF, 32'hFFFFFFFF, 32'hFFFFFFFF,
        32'h1FFFF, 32'h1FFFF, 32'h1FFFF, 32'h1FFFF, 32'hFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
    localparam logic [7:0] RO [9] = '{8'h00, 8'h08, 8'h14, 8'h30, 8'h38, 8'h3C, 8'h40, 8'h44, 8'h54};
    logic               hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, crst = 0, cact = 0, rd_dp = 0;
    logic               hready, hreadyout, fc, fp;
    logic [1:0]         htrans = 0;
    logic [31:0]        haddr = 0, hwdata = 0, hrdata, volt, ext, fbk, bang, oang, ia, rot, vg, ig, pg, d, e, r, oc;
    logic signed [31:0] smp, spd, sset, ccmd, pcmd;
    logic [16:0]        bmag, el, f1, f2;
    logic [7:0]         pgs;
    logic [31:0]        v [12];    // values last written, masked
    logic [31:0]        exp_q [$]; // expected read data, oldest first
    logic [63:0]        t;
    int                 mismatches = 0, tests_run = 0, seed;
    assign hready = hreadyout; // single slave drives the bus ready
    focpsr_regs #(.PROP_GAIN_SHIFT(SH)) u_focpsr_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .core_reset(crst), .core_activate(cact),
        .volt_vector_angle_in(volt), .external_angle_in(ext), .feedback_default_angle(fbk),
        .speed_sample_in(smp), .bemf_angle_in(bang), .bemf_magnitude_in(bmag), .observer_angle_in(oang),
        .initial_angle_out(ia), .initial_angle_load(), .rotor_angle(rot), .electric_speed(spd),
        .observer_voltage_gain(vg), .observer_current_gain(ig), .observer_error_limit(el),
        .bemf_filter_one_coef(f1), .bemf_filter_two_coef_live(f2), .observer_angle_corrected(oc),
        .speed_loop_setpoint(sset), .speed_loop_prop_gain(pg), .prop_gain_shift(pgs),
        .speed_feeds_current_loop(fc), .speed_feeds_position_loop(fp), .speed_to_current_cmd(ccmd),
        .speed_to_position_cmd(pcmd));
    initial forever #10 hclk = ~hclk;
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // bounded wait for ready; a hung bus ends the run
    task automatic wait_rdy;
        repeat (20)
        begin
            @(posedge hclk);
            if (hready === 1'b1)
                return;
        end
        mismatches++;
        summarize();
    endtask
    // one single word transfer, address phase then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        rd_dp <= !w;
        wait_rdy();
        rd_dp <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        bus(1'b1, a, wd);
    endtask
    // the expectation is noted before the read goes out
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        exp_q.push_back(x);
        bus(1'b0, a, 32'h0);
    endtask
    // read data is compared at the edge that ends its data phase
    always @(posedge hclk)
    begin
        if (rd_dp)
        begin
            e = exp_q.pop_front();
            `CHK(hrdata, e)
        end
    end
    initial
    begin
        seed = 32'hE1140E2E;
        volt = $random(seed);
        ext = $random(seed);
        fbk = $random(seed);
        bang = $random(seed);
        oang = $random(seed);
        bmag = 17'($random(seed));
        smp = 32'sh00400000; // divisible by four so the half weights stay exact
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (OFS[i]) rd(OFS[i], 32'h0);
        rd(8'h50, 32'h0);
        $display("test reset values done");
        foreach (OFS[i])
        begin
            d = $random(seed);
            v[i] = d & MSK[i];
            wr(OFS[i], d);
            rd(OFS[i], v[i]);
        end
        `CHK(ia, v[0])
        `CHK(vg, v[3])
        `CHK(ig, v[4])
        `CHK(el, v[5][16:0])
        `CHK(f1, v[6][16:0])
        `CHK(f2, v[7][16:0])
        `CHK(sset, v[10])
        `CHK(pg, v[11])
        `CHK(pgs, 8'(SH))
        `CHK(oc, oang + {{16{v[9][15]}}, v[9][15:0]})
        $display("test read write done");
        // writes to read-only and unmapped places must change nothing
        foreach (RO[i]) wr(RO[i], $random(seed));
        rd(8'h00, volt);
        rd(8'h38, bang);
        rd(8'h3C, {15'h0, bmag});
        rd(8'h40, oang);
        rd(8'h14, 32'h0);
        rd(8'h30, v[7]);
        rd(8'h54, 32'h0);
        foreach (OFS[i]) rd(OFS[i], v[i]);
        $display("test read only done");
        // source 2 reads the speed integrator, still at its reset value of zero here
        for (int s = 0; s < 4; s++)
        begin
            r = s == 0 ? oang + {{16{v[9][15]}}, v[9][15:0]} : s == 1 ? ext : s == 2 ? 32'h0 : fbk;
            wr(8'h50, {28'h0, 2'(s), 2'h3});
            repeat (3) @(posedge hclk);
            rd(8'h08, r);
            rd(8'h44, {16'h0, r[31:16]});
            rd(8'h50, {28'h0, 2'(s), 2'h3});
            `CHK(ccmd, sset)
            `CHK({fc, fp}, 2'h3)
        end
        for (int s = 0; s < 4; s++)
        begin
            wr(8'h50, {28'h0, 2'(s), 2'h0});
            crst <= 1'b1;
            repeat (2) @(posedge hclk);
            `CHK(rot, (s % 2) ? fbk : v[0])
            `CHK({fc, fp}, 2'h0)
            `CHK(ccmd, 32'h0)
            `CHK(pcmd, 32'h0)
            crst <= 1'b0;
            @(posedge hclk);
        end
        $display("test rotor source done");
        // half weights: stage two outputs X/4 after one step, X/2 after two
        wr(8'h0C, 32'h10000);
        wr(8'h10, 32'h10000);
        wr(8'h50, 32'h3);
        crst <= 1'b1;
        @(posedge hclk);
        crst <= 1'b0;
        for (int k = 1; k < 3; k++)
        begin
            @(posedge hclk);
            cact <= 1'b1;
            @(posedge hclk);
            cact <= 1'b0;
            repeat (3) @(posedge hclk);
            `CHK(spd, smp * k / 4)
        end
        rd(8'h14, smp / 2);
        `CHK(pcmd, smp / 2)
        t = 64'(v[7][16:0]) + ((64'(v[8][16:0]) * 64'h20) >> 16);
        rd(8'h30, (t > 64'h1FFFF) ? 32'h1FFFF : t[31:0]);
        $display("test speed filter done");
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(8'h48, 32'h0);
        $display("test second reset done");
        summarize();
    end
endmodule
